//--- core/sgp_consts.svh
// Register map, field positions, reset values and widths of the pin/pen/conversion block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef SGP_CONSTS_SVH
`define SGP_CONSTS_SVH
`define SGP_ADDR_W        8
`define SGP_DATA_W        10
`define SGP_INPUT_SELECT_W        2
`define SGP_NPIN          4
`define SGP_OFS_PIN_CTRL  8'h00
`define SGP_OFS_CONV_CTRL 8'h04
`define SGP_OFS_RESULT    8'h08
`define SGP_OFS_IRQ_STAT  8'h0c
`define SGP_OFS_IRQ_MASK  8'h10
`define SGP_PIN_LVL_LSB   0
`define SGP_PIN_OE_LSB    4
`define SGP_PEN_EN_BIT    8
`define SGP_PEN_STAT_BIT  9
`define SGP_CC_START_BIT  0
`define SGP_CC_TOUCH_BIT  1
`define SGP_RES_INPUT_SELECT_LSB  12
`define SGP_RES_BUSY_BIT  15
`define SGP_IRQ_DONE_BIT  0
`define SGP_IRQ_PEN_BIT   1
`define SGP_NIRQ          2
`define SGP_PIN_CTRL_RST  9'h000
`define SGP_OE_N_RST      4'hf
`define SGP_RESP_OKAY     2'h0
`define SGP_RESP_SLVERR   2'h2
`endif

//--- core/sgp_pkg.sv
// Types shared by the pin/pen/conversion block.
// Assumes sgp_consts.svh is on the include path.
`include "sgp_consts.svh"
package sgp_pkg;
	typedef enum logic [0:0] {
		SGP_STANDBY = 1'b0,
		SGP_CONVERT = 1'b1
	} sgp_state_e;

	typedef struct packed {
		logic [`SGP_NPIN-1:0] level;
		logic [`SGP_NPIN-1:0] oe_n;
	} sgp_pin_s;

	typedef struct packed {
		logic                  touch;
		logic [1:0]            pos_sel;
		logic [1:0]            neg_sel;
	} sgp_ref_s;

	typedef struct packed {
		logic                  awready;
		logic                  wready;
		logic                  aw_got;
		logic                  w_got;
		logic [`SGP_ADDR_W-1:0] awaddr;
		logic [15:0]           wdata;
		logic [1:0]            wstrb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  arready;
		logic                  rvalid;
		logic [1:0]            rresp;
		logic [15:0]           rdata;
	} sgp_bus_s;

	typedef struct packed {
		sgp_bus_s              bus;
		logic [8:0]            pin_ctrl;
		logic                  pen;
		logic                  touch_mode;
		logic                  start;
		logic                  busy;
		logic                  standby;
		sgp_state_e            state;
		logic [`SGP_INPUT_SELECT_W-1:0] sel;
		logic [`SGP_DATA_W-1:0] result;
		logic                  conv_go;
		logic [`SGP_NIRQ-1:0]  status;
		logic [`SGP_NIRQ-1:0]  mask;
		logic                  irq;
		sgp_pin_s              pin;
		sgp_ref_s              refs;
	} sgp_state_s;
endpackage

//--- core/sgp_top.sv
// Pin output, pen status and conversion sequencing block with an AXI4-Lite slave.
// Assumes a converter core that takes a start pulse and answers with a done pulse.
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "sgp_consts.svh"
module sgp_top (
	// Clock, reset, enable
	input  wire logic                   core_clk_in,
	input  wire logic                   sys_rst_in,
	input  wire logic                   clk_en_in,
	// AXI4-Lite write address
	input  wire logic                   s_axi_awvalid_in,
	input  wire logic [`SGP_ADDR_W-1:0] s_axi_awaddr_in,
	output logic                        s_axi_awready_out,
	// AXI4-Lite write data
	input  wire logic                   s_axi_wvalid_in,
	input  wire logic [31:0]            s_axi_wdata_in,
	input  wire logic [3:0]             s_axi_wstrb_in,
	output logic                        s_axi_wready_out,
	// AXI4-Lite write response
	output logic                        s_axi_bvalid_out,
	output logic [1:0]                  s_axi_bresp_out,
	input  wire logic                   s_axi_bready_in,
	// AXI4-Lite read address
	input  wire logic                   s_axi_arvalid_in,
	input  wire logic [`SGP_ADDR_W-1:0] s_axi_araddr_in,
	output logic                        s_axi_arready_out,
	// AXI4-Lite read data
	output logic                        s_axi_rvalid_out,
	output logic [31:0]                 s_axi_rdata_out,
	output logic [1:0]                  s_axi_rresp_out,
	input  wire logic                   s_axi_rready_in,
	// Converter core
	output logic                        conv_start_out,
	output logic [`SGP_INPUT_SELECT_W-1:0]      conv_channel_out,
	output logic                        conv_standby_out,
	input  wire logic                   conv_done_in,
	input  wire logic [`SGP_DATA_W-1:0] conv_data_in,
	// Pen detector
	input  wire logic                   pen_detect_in,
	// Analog pins used as outputs
	output logic [`SGP_NPIN-1:0]        pin_level_out,
	output logic [`SGP_NPIN-1:0]        pin_oe_n_out,
	// Reference steering for touch panel mode
	output logic                        ref_touch_out,
	output logic [1:0]                  ref_pos_sel_out,
	output logic [1:0]                  ref_neg_sel_out,
	// Interrupt
	output logic                        irq_out
);

	localparam sgp_pkg::sgp_state_s RST_VAL = '{
		bus:        '0,
		pin_ctrl:   `SGP_PIN_CTRL_RST,
		pen:        1'b0,
		touch_mode: 1'b0,
		start:      1'b0,
		busy:       1'b0,
		standby:    1'b1,
		state:      sgp_pkg::SGP_STANDBY,
		sel:        '0,
		result:     '0,
		conv_go:    1'b0,
		status:     '0,
		mask:       '0,
		irq:        1'b0,
		pin:        '{level: '0, oe_n: `SGP_OE_N_RST},
		refs:       '0
	};

	sgp_pkg::sgp_state_s q;
	sgp_pkg::sgp_state_s n;

	always_comb begin
		logic [15:0]           m;
		logic [15:0]           rd;
		logic [`SGP_NIRQ-1:0]  set;
		logic [`SGP_NIRQ-1:0]  clr;
		logic                  do_wr;
		logic                  start_req;
		logic [`SGP_NPIN-1:0]  oe;
		logic [`SGP_NPIN-1:0]  lv;
		m = {{8{q.bus.wstrb[1]}}, {8{q.bus.wstrb[0]}}};
		rd = 16'h0000;
		set = '0;
		clr = '0;
		start_req = 1'b0;
		do_wr = 1'b0;
		oe = '0;
		lv = '0;
		n = q;
		n.conv_go = 1'b0;

		// Address and data are caught independently
		if (s_axi_awvalid_in && q.bus.awready) begin
			n.bus.aw_got = 1'b1;
			n.bus.awaddr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && q.bus.wready) begin
			n.bus.w_got = 1'b1;
			n.bus.wdata = s_axi_wdata_in[15:0];
			n.bus.wstrb = s_axi_wstrb_in[1:0];
		end
		if (q.bus.bvalid && s_axi_bready_in) begin
			n.bus.bvalid = 1'b0;
		end

		do_wr = q.bus.aw_got && q.bus.w_got && !q.bus.bvalid;
		if (do_wr) begin
			n.bus.aw_got = 1'b0;
			n.bus.w_got = 1'b0;
			n.bus.bvalid = 1'b1;
			n.bus.bresp = `SGP_RESP_OKAY;
			case ({q.bus.awaddr[`SGP_ADDR_W-1:2], 2'b00})
				`SGP_OFS_PIN_CTRL: begin
					n.pin_ctrl = (q.pin_ctrl & ~m[8:0]) | (q.bus.wdata[8:0] & m[8:0]);
				end
				`SGP_OFS_CONV_CTRL: begin
					if (m[`SGP_CC_START_BIT] && q.bus.wdata[`SGP_CC_START_BIT]) begin
						start_req = 1'b1;
					end
					if (m[`SGP_CC_TOUCH_BIT]) begin
						n.touch_mode = q.bus.wdata[`SGP_CC_TOUCH_BIT];
					end
				end
				`SGP_OFS_RESULT: begin
					// Input number is frozen while a conversion runs
					if (m[`SGP_RES_INPUT_SELECT_LSB + 1] && !q.busy) begin
						n.sel = q.bus.wdata[`SGP_RES_INPUT_SELECT_LSB +: `SGP_INPUT_SELECT_W];
					end
				end
				`SGP_OFS_IRQ_STAT: begin
					clr = q.bus.wdata[`SGP_NIRQ-1:0] & m[`SGP_NIRQ-1:0];
				end
				`SGP_OFS_IRQ_MASK: begin
					if (m[0]) begin
						n.mask = q.bus.wdata[`SGP_NIRQ-1:0];
					end
				end
				default: begin
					n.bus.bresp = `SGP_RESP_SLVERR;
				end
			endcase
		end

		// Read path
		if (q.bus.rvalid && s_axi_rready_in) begin
			n.bus.rvalid = 1'b0;
		end
		if (s_axi_arvalid_in && q.bus.arready) begin
			n.bus.rvalid = 1'b1;
			n.bus.rresp = `SGP_RESP_OKAY;
			case ({s_axi_araddr_in[`SGP_ADDR_W-1:2], 2'b00})
				`SGP_OFS_PIN_CTRL: begin
					rd[8:0] = q.pin_ctrl;
					rd[`SGP_PEN_STAT_BIT] = q.pen;
				end
				`SGP_OFS_CONV_CTRL: begin
					rd[`SGP_CC_START_BIT] = q.start;
					rd[`SGP_CC_TOUCH_BIT] = q.touch_mode;
				end
				`SGP_OFS_RESULT: begin
					rd[`SGP_DATA_W-1:0] = q.result;
					rd[`SGP_RES_INPUT_SELECT_LSB +: `SGP_INPUT_SELECT_W] = q.sel;
					rd[`SGP_RES_BUSY_BIT] = q.busy;
				end
				`SGP_OFS_IRQ_STAT: begin
					rd[`SGP_NIRQ-1:0] = q.status;
				end
				`SGP_OFS_IRQ_MASK: begin
					rd[`SGP_NIRQ-1:0] = q.mask;
				end
				default: begin
					n.bus.rresp = `SGP_RESP_SLVERR;
				end
			endcase
			n.bus.rdata = rd;
		end

		// Conversion sequencing
		case (q.state)
			sgp_pkg::SGP_STANDBY: begin
				if (start_req) begin
					n.state = sgp_pkg::SGP_CONVERT;
					n.start = 1'b1;
					n.busy = 1'b1;
					n.conv_go = 1'b1;
				end
			end
			sgp_pkg::SGP_CONVERT: begin
				if (conv_done_in) begin
					n.state = sgp_pkg::SGP_STANDBY;
					n.start = 1'b0;
					n.busy = 1'b0;
					n.result = conv_data_in;
					set[`SGP_IRQ_DONE_BIT] = 1'b1;
				end
			end
			default: begin
				n.state = sgp_pkg::SGP_STANDBY;
			end
		endcase

		// Standby indication is registered so the pin comes straight from a flop
		n.standby = !n.busy;

		// Pen contact level and its rising edge event
		n.pen = pen_detect_in;
		set[`SGP_IRQ_PEN_BIT] = pen_detect_in && !q.pen;

		// A new event beats a clear in the same cycle
		n.status = (q.status & ~clr) | set;
		n.irq = (|(n.status & n.mask)) || (n.pen && n.pin_ctrl[`SGP_PEN_EN_BIT]);

		// Pin drivers
		oe = n.pin_ctrl[`SGP_PIN_OE_LSB +: `SGP_NPIN];
		lv = n.pin_ctrl[`SGP_PIN_LVL_LSB +: `SGP_NPIN];
		n.pin.oe_n = ~oe;
		n.pin.level = lv & oe;

		// Axis decode: one pin of a pair driven high, the other low
		n.refs = '0;
		if (n.touch_mode) begin
			if (oe[0] && oe[2] && lv[0] && !lv[2]) begin
				n.refs.touch = 1'b1;
				n.refs.pos_sel = 2'd0;
				n.refs.neg_sel = 2'd2;
			end else if (oe[1] && oe[3] && lv[1] && !lv[3]) begin
				n.refs.touch = 1'b1;
				n.refs.pos_sel = 2'd1;
				n.refs.neg_sel = 2'd3;
			end
		end

		n.bus.awready = !n.bus.aw_got && !n.bus.bvalid;
		n.bus.wready = !n.bus.w_got && !n.bus.bvalid;
		n.bus.arready = !n.bus.rvalid;
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			q <= RST_VAL;
		end else if (clk_en_in) begin
			q <= n;
		end
	end

	assign s_axi_awready_out = q.bus.awready;
	assign s_axi_wready_out  = q.bus.wready;
	assign s_axi_bvalid_out  = q.bus.bvalid;
	assign s_axi_bresp_out   = q.bus.bresp;
	assign s_axi_arready_out = q.bus.arready;
	assign s_axi_rvalid_out  = q.bus.rvalid;
	assign s_axi_rdata_out   = {16'h0000, q.bus.rdata};
	assign s_axi_rresp_out   = q.bus.rresp;
	assign conv_start_out    = q.conv_go;
	assign conv_channel_out  = q.sel;
	assign conv_standby_out  = q.standby;
	assign pin_level_out     = q.pin.level;
	assign pin_oe_n_out      = q.pin.oe_n;
	assign ref_touch_out     = q.refs.touch;
	assign ref_pos_sel_out   = q.refs.pos_sel;
	assign ref_neg_sel_out   = q.refs.neg_sel;
	assign irq_out           = q.irq;

endmodule // sgp_top

//--- verif/sgp_monitor.sv
// Assertion checker for the pin/pen/conversion block.
// Assumes it is bound onto sgp_top and sees only its ports.
`timescale 1ns/100ps
module sgp_monitor (
	// Watched ports
	input wire logic        core_clk_in,
	input wire logic        sys_rst_in,
	input wire logic        conv_start_out,
	input wire logic        conv_standby_out,
	input wire logic        conv_done_in,
	input wire logic [3:0]  pin_level_out,
	input wire logic [3:0]  pin_oe_n_out,
	input wire logic        s_axi_rvalid_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic        ref_touch_out,
	input wire logic [1:0]  ref_pos_sel_out,
	input wire logic [1:0]  ref_neg_sel_out,
	input wire logic        irq_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	sequence conv_end;
		!conv_standby_out && conv_done_in;
	endsequence
	level_gate_a: assert property ((pin_level_out & pin_oe_n_out) == 4'h0)
		else $error("level on undriven pin");
	start_pulse_a: assert property (conv_start_out |=> !conv_start_out)
		else $error("start pulse too long");
	start_busy_a: assert property (conv_start_out |-> !conv_standby_out)
		else $error("standby during start");
	done_idle_a: assert property (conv_end |=> conv_standby_out && !conv_start_out)
		else $error("no standby after done");
	standby_hold_a: assert property ($fell(conv_standby_out) |-> conv_start_out)
		else $error("left standby without start");
	resv_zero_a: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:16] == 16'h0)
		else $error("upper read bits set");
	touch_pair_a: assert property (ref_touch_out |->
		{ref_pos_sel_out, ref_neg_sel_out} inside {4'h2, 4'h7})
		else $error("bad reference pair");
	reset_val_a: assert property ($past(sys_rst_in) |->
		pin_oe_n_out == 4'hf && !irq_out && conv_standby_out)
		else $error("bad reset value");
endmodule // sgp_monitor

bind sgp_top sgp_monitor sgp_monitor_inst (.core_clk_in, .sys_rst_in, .conv_start_out,
	.conv_standby_out, .conv_done_in, .pin_level_out, .pin_oe_n_out, .s_axi_rvalid_out,
	.s_axi_rdata_out, .ref_touch_out, .ref_pos_sel_out, .ref_neg_sel_out, .irq_out);

//--- verif/sgp_conv_model.sv
// Behavioural converter core answering a start pulse after a set latency.
// Assumes the bench supplies the latency and the value to return.
`timescale 1ns/100ps
module sgp_conv_model (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// Request
	input  wire logic       start_in,
	input  wire logic [7:0] lat_in,
	input  wire logic [9:0] val_in,
	// Answer
	output logic            done_out,
	output logic [9:0]      data_out
);
	logic [7:0] cnt_q;
	// Data is meaningless outside the done pulse
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt_q    <= 8'h00;
			done_out <= 1'b0;
			data_out <= 10'h000;
		end else if (start_in) begin
			cnt_q    <= lat_in;
			done_out <= 1'b0;
			data_out <= ~data_out;
		end else if (cnt_q == 8'h01) begin
			cnt_q    <= 8'h00;
			done_out <= 1'b1;
			data_out <= val_in;
		end else begin
			cnt_q    <= (cnt_q != 8'h00) ? cnt_q - 8'h01 : 8'h00;
			done_out <= 1'b0;
			data_out <= ~data_out;
		end
	end
endmodule // sgp_conv_model

//--- verif/test_sgp_top.sv
// Self-checking bench for the pin/pen/conversion block.
// Assumes sgp_top, sgp_conv_model and the bound checker are compiled.
`timescale 1ns/100ps
module test_sgp_top;
	logic        clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, pen = 0, en = 1;
	logic        awr, wrd, bv, arr, rv, cst, sby, done, rt, irq;
	logic [1:0]  br, rr, rp, rn, cch, ch;
	logic [3:0]  lvl, oen;
	logic [7:0]  awa = 0, ara = 0, lat = 0;
	logic [9:0]  cdat, val = 0, last = 0;
	logic [15:0] v;
	logic [31:0] wd = 0, rdat;
	logic [33:0] rq[$], bq[$];
	logic [15:0] tv[3] = '{16'h51, 16'ha2, 16'h0};
	logic [4:0]  te[3] = '{5'h12, 5'h17, 5'h0};
	int          num_errors = 0, samples_checked = 0;
	always #2 clk = ~clk;
	sgp_top sgp_top_inst (.core_clk_in(clk), .sys_rst_in(rst), .clk_en_in(en),
		.s_axi_awvalid_in(awv), .s_axi_awaddr_in(awa), .s_axi_awready_out(awr),
		.s_axi_wvalid_in(wv), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf),
		.s_axi_wready_out(wrd), .s_axi_bvalid_out(bv), .s_axi_bresp_out(br),
		.s_axi_bready_in(bry), .s_axi_arvalid_in(arv), .s_axi_araddr_in(ara),
		.s_axi_arready_out(arr), .s_axi_rvalid_out(rv), .s_axi_rdata_out(rdat),
		.s_axi_rresp_out(rr), .s_axi_rready_in(rry), .conv_start_out(cst),
		.conv_channel_out(cch), .conv_standby_out(sby), .conv_done_in(done),
		.conv_data_in(cdat), .pen_detect_in(pen), .pin_level_out(lvl),
		.pin_oe_n_out(oen), .ref_touch_out(rt), .ref_pos_sel_out(rp),
		.ref_neg_sel_out(rn), .irq_out(irq));
	sgp_conv_model sgp_conv_model_inst (.clk_in(clk), .rst_in(rst), .start_in(cst),
		.lat_in(lat), .val_in(val), .done_out(done), .data_out(cdat));
	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r = 2'h0);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		bq.push_back({r, 32'h0});
		@(posedge clk);
		awv <= 1'b1;
		wv <= 1'b1;
		awa <= a;
		wd <= {16'h0, d};
		bry <= 1'b1;
		// Each channel is released at its own handshake
		while (!(aw_ok && w_ok)) begin
			@(posedge clk);
			if (!aw_ok && awr) begin
				aw_ok = 1'b1;
				awv <= 1'b0;
			end
			if (!w_ok && wrd) begin
				w_ok = 1'b1;
				wv <= 1'b0;
			end
		end
		do @(posedge clk); while (!bv);
		bry <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r = 2'h0);
		rq.push_back({r, 16'h0, d});
		@(posedge clk);
		arv <= 1;
		ara <= a;
		rry <= 1;
		do @(posedge clk); while (!arr);
		arv <= 0;
		do @(posedge clk); while (!rv);
		rry <= 0;
	endtask
	task automatic stop_test;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Answers are compared in arrival order
	always @(posedge clk) begin
		if (rv && rry) begin
			if (rq.size() == 0) begin
				num_errors++;
				$display("[FAIL] %0t unexpected read answer", $time);
			end else begin
				chk({rr, rdat}, rq.pop_front());
			end
		end
		if (bv && bry) begin
			if (bq.size() == 0) begin
				num_errors++;
				$display("[FAIL] %0t unexpected write answer", $time);
			end else begin
				chk({br, 32'h0}, bq.pop_front());
			end
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		stop_test();
	end
	initial begin
		void'($urandom(95287));
		repeat (8) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		rd(8'h00, 16'h0);
		rd(8'h14, 16'h0, 2'h2);
		wr(8'h14, 16'hffff, 2'h2);
		for (int i = 0; i < 8; i++) begin
			v = {8'hfe, 8'($urandom)};
			wr(8'h00, v);
			chk({oen, lvl}, {~v[7:4], v[3:0] & v[7:4]});
			rd(8'h00, {8'h0, v[7:0]});
		end
		wr(8'h04, 16'h2);
		for (int i = 0; i < 3; i++) begin
			wr(8'h00, tv[i]);
			repeat (2) @(posedge clk);
			chk({rt, rp, rn}, te[i]);
		end
		for (int i = 0; i < 4; i++) begin
			ch = 2'(i);
			val <= 10'($urandom);
			lat <= 8'(16 + $urandom % 40);
			wr(8'h08, {2'h0, ch, 12'h0});
			chk(cch, ch);
			wr(8'h04, 16'h1);
			rd(8'h08, {2'h2, ch, 2'h0, last});
			do @(posedge clk); while (!sby);
			last = val;
			rd(8'h08, {2'h0, ch, 2'h0, val});
			rd(8'h04, 16'h0);
		end
		rd(8'h0c, 16'h1);
		chk(irq, 1'b0);
		wr(8'h10, 16'h1);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		wr(8'h0c, 16'h1);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		pen <= 1;
		repeat (3) @(posedge clk);
		rd(8'h00, 16'h200);
		chk(irq, 1'b0);
		rd(8'h0c, 16'h2);
		wr(8'h00, 16'h100);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		pen <= 0;
		repeat (3) @(posedge clk);
		chk(irq, 1'b0);
		// Low enable freezes all state, then it resumes
		en <= 0;
		pen <= 1;
		repeat (4) @(posedge clk);
		chk(irq, 1'b0);
		en <= 1;
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		pen <= 0;
		repeat (3) @(posedge clk);
		chk(irq, 1'b0);
		// Reset in mid-run with every pin driven high
		wr(8'h00, 16'h1ff);
		chk({oen, lvl}, 8'h0f);
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		chk({oen, lvl}, 8'hf0);
		rd(8'h00, 16'h0);
		rd(8'h0c, 16'h0);
		stop_test();
	end
endmodule // test_sgp_top
